// *** core/tmr_core.sv ***
// two-wire bus master receiver with axi4-lite register slave
//
// Contract
// RL1 - start request waits bus free, then START
// RL2 - writing one clears flag; enable gates operation
// RL3 - after START set flag, status 08
// RL4 - address direction bit selects transmit or receive
// RL5 - software loads read address then clears flag
// RL6 - after read address report 38, 40 or 48
// RL7 - received byte readable when flag rises
// RL8 - software clears ack enable before last byte
// RL9 - stop request sends STOP, bit self-clears
// RL10 - start request sends repeated START, status 10
// RL11 - in 10 direction bit picks next mode
// RL12 - on 38 release bus or restart later
// RL13 - on 40 receive byte, ack per enable
// RL14 - on 48 restart, stop, or stop+start
// RL15 - on 50 receive next byte, ack per enable
// RL16 - on 58 restart, stop, or stop+start
// RL17 - software masks prescaler bits before compare
// RL18 - data write without flag discarded, collision set
// RL19 - clock held low while flag set; the code releases it when the flag rises with 38
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module tmr_core
  import tmr_pkg::*;
#(
  parameter int ADDR_W      = 8,
  parameter int HALF_CYCLES = HALF_CYC
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // bus pins, open drain
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe,
  // interrupt
  output logic                   irq
);

  localparam logic [TMR_W-1:0] HALF = TMR_W'(HALF_CYCLES - 1);

  typedef struct packed {
    tmr_state_e        state;
    logic              flag;
    logic              ack_en;
    logic              sta;
    logic              sto;
    logic              wcol;
    logic              en;
    logic              ie;
    logic [7:0]        code;
    logic [1:0]        presc;
    logic [7:0]        data;
    logic [7:0]        shift;
    logic [3:0]        nbit;
    logic [1:0]        phase;
    logic              rx_mode;
    logic              rxing;
    logic              addr_phase;
    logic              rep;
    logic [TMR_W-1:0]  tmr;
    logic              scl_m;
    logic              scl_s;
    logic              sda_m;
    logic              sda_s;
    logic              sda_p;
    logic              busy;
    logic              scl_oe;
    logic              sda_oe;
    logic [2:0]        ists;
    logic [2:0]        imask;
    logic              irq;
    logic              aw_have;
    logic [ADDR_W-1:0] awaddr;
    logic              w_have;
    logic [7:0]        wdata;
    logic              wstrb0;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } tmr_regs_s;

  tmr_regs_s q;
  tmr_regs_s n;

  // status code after the ack slot of a byte
  function automatic logic [7:0] f_code(input logic addr, input logic rx, input logic ack);
    if (addr)
      f_code = rx ? (ack ? ST_AR_ACK : ST_AR_NACK) : (ack ? ST_AW_ACK : ST_AW_NACK);
    else
      f_code = rx ? (ack ? ST_RX_ACK : ST_RX_NACK) : (ack ? ST_DT_ACK : ST_DT_NACK);
  endfunction

  always_comb begin
    logic tdone;
    logic bitv;
    logic drove;
    n     = q;
    tdone = (q.tmr == '0);
    bitv  = 1'b1;
    drove = 1'b0;
    if (!tdone)
      n.tmr = q.tmr - TMR_W'(1);

    // pin synchronisers and bus busy tracking
    n.scl_m = scl_i;
    n.scl_s = q.scl_m;
    n.sda_m = sda_i;
    n.sda_s = q.sda_m;
    n.sda_p = q.sda_s;
    if (q.scl_s && q.sda_p && !q.sda_s)
      n.busy = 1'b1;
    if (q.scl_s && !q.sda_p && q.sda_s)
      n.busy = 1'b0;

    // axi write channels, taken in either order
    if (s_axi_awvalid && q.awready) begin
      n.aw_have = 1'b1;
      n.awaddr  = s_axi_awaddr;
      n.awready = 1'b0;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_have = 1'b1;
      n.wdata  = s_axi_wdata[7:0];
      n.wstrb0 = s_axi_wstrb[0];
      n.wready = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = RESP_OK;
      unique case (8'(q.awaddr))
        OFS_CTRL: if (q.wstrb0) begin
          if (q.wdata[B_FLAG])
            n.flag = 1'b0; // RL2
          n.ack_en = q.wdata[B_ACK];
          n.sta    = q.wdata[B_STA];
          n.sto    = q.wdata[B_STO];
          n.en     = q.wdata[B_EN]; // RL2
          n.ie     = q.wdata[B_IE];
        end
        OFS_STAT: if (q.wstrb0)
          n.presc = q.wdata[1:0];
        OFS_DATA: if (q.wstrb0) begin
          if (q.flag) begin
            n.data = q.wdata;
            n.wcol = 1'b0;
          end else begin
            n.wcol          = 1'b1; // RL18
            n.ists[I_WCOL]  = 1'b1;
          end
        end
        OFS_ISTS: if (q.wstrb0)
          n.ists = q.ists & ~q.wdata[2:0];
        OFS_IMSK: if (q.wstrb0)
          n.imask = q.wdata[2:0];
        default: n.bresp = RESP_SLV;
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid  = 1'b0;
      n.awready = 1'b1;
      n.wready  = 1'b1;
    end

    // axi read channel
    if (s_axi_arvalid && q.arready) begin
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rresp   = RESP_OK;
      unique case (8'(s_axi_araddr))
        OFS_CTRL: n.rdata = {24'h0, q.flag, q.ack_en, q.sta, q.sto, q.wcol, q.en, 1'b0, q.ie};
        OFS_STAT: n.rdata = {24'h0, q.code[7:3], 1'b0, q.presc}; // RL17
        OFS_DATA: n.rdata = {24'h0, q.data}; // RL7
        OFS_ISTS: n.rdata = {29'h0, q.ists};
        OFS_IMSK: n.rdata = {29'h0, q.imask};
        default: begin
          n.rdata = 32'h0;
          n.rresp = RESP_SLV;
        end
      endcase
    end
    if (q.rvalid && s_axi_rready) begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end

    // bus engine; engine sets come after software clears so a set wins
    unique case (q.state)
      S_IDLE: begin
        n.scl_oe = 1'b0;
        n.sda_oe = 1'b0;
        if (q.en && q.sta && !q.flag && !q.busy) begin // RL1 RL12
          n.state  = S_START;
          n.phase  = 2'd0;
          n.sda_oe = 1'b1;
          n.tmr    = HALF;
        end
      end
      S_START: if (tdone) begin
        if (q.phase == 2'd0) begin
          n.phase  = 2'd1;
          n.scl_oe = 1'b1;
          n.tmr    = HALF;
        end else begin
          n.state        = S_HOLD;
          n.flag         = 1'b1;
          n.ists[I_DONE] = 1'b1;
          n.addr_phase   = 1'b1;
          n.code         = q.rep ? ST_RSTART : ST_START; // RL3 RL10
        end
      end
      S_HOLD: begin
        n.scl_oe = 1'b1; // RL19
        if (!q.flag) begin
          n.phase = 2'd0;
          n.tmr   = HALF;
          if (q.sto) begin // RL9 RL14 RL16
            n.state  = S_STOP;
            n.sda_oe = 1'b1;
          end else if (q.sta) begin // RL10 RL14 RL16
            n.state  = S_RSTART;
            n.sda_oe = 1'b0;
          end else if (q.code == ST_AR_NACK || q.code == ST_RX_NACK) begin
            // no bus action is defined here; end the frame rather than hang it
            n.state  = S_STOP;
            n.sda_oe = 1'b1;
          end else begin
            n.state = S_BIT;
            n.nbit  = 4'd0;
            n.shift = q.data;
            if (q.addr_phase)
              n.rx_mode = q.data[0]; // RL4 RL11
            n.rxing = !q.addr_phase && q.rx_mode; // RL13 RL15
          end
        end
      end
      S_BIT: begin
        if (q.nbit == 4'd8)
          bitv = q.rxing ? !q.ack_en : 1'b1; // RL13 RL15
        else
          bitv = q.rxing ? 1'b1 : q.shift[7];
        drove = q.rxing ? (q.nbit == 4'd8) : (q.nbit != 4'd8);
        if (q.phase == 2'd0) begin
          n.scl_oe = 1'b1;
          n.sda_oe = !bitv;
          if (tdone) begin
            n.phase  = 2'd1;
            n.scl_oe = 1'b0;
            n.tmr    = HALF;
          end
        end else if (!q.scl_s) begin
          // slave stretches the clock; high time starts once it lets go
          n.tmr = HALF;
        end else if (tdone) begin
          if (drove && bitv && !q.sda_s) begin // RL12
            n.state        = S_IDLE;
            n.scl_oe       = 1'b0;
            n.sda_oe       = 1'b0;
            n.rep          = 1'b0;
            n.addr_phase   = 1'b0;
            n.flag         = 1'b1;
            n.code         = ST_ARB; // RL6
            n.ists[I_DONE] = 1'b1;
            n.ists[I_ARB]  = 1'b1;
          end else begin
            n.phase  = 2'd0;
            n.scl_oe = 1'b1;
            n.tmr    = HALF;
            if (q.nbit != 4'd8) begin
              n.shift = {q.shift[6:0], q.sda_s};
              n.nbit  = q.nbit + 4'd1;
            end else begin
              n.state        = S_HOLD;
              n.flag         = 1'b1;
              n.ists[I_DONE] = 1'b1;
              n.addr_phase   = 1'b0;
              n.code         = f_code(q.addr_phase, q.rx_mode, q.rxing ? q.ack_en : !q.sda_s); // RL6
              if (q.rxing)
                n.data = q.shift; // RL7
            end
          end
        end
      end
      S_STOP: if (q.phase == 2'd1 && !q.scl_s) begin
        n.tmr = HALF;
      end else if (tdone) begin
        n.tmr   = HALF;
        n.phase = q.phase + 2'd1;
        if (q.phase == 2'd0)
          n.scl_oe = 1'b0;
        else if (q.phase == 2'd1)
          n.sda_oe = 1'b0;
        else begin
          // a pending start request restarts from idle once the bus is free
          n.state = S_IDLE;
          n.sto   = 1'b0; // RL9
          n.rep   = 1'b0;
          n.code  = ST_NONE;
        end
      end
      S_RSTART: if (tdone) begin
        n.tmr = HALF;
        if (q.phase == 2'd0) begin
          n.phase  = 2'd1;
          n.scl_oe = 1'b0;
        end else if (q.scl_s) begin
          n.state  = S_START; // RL10
          n.phase  = 2'd0;
          n.rep    = 1'b1;
          n.sda_oe = 1'b1;
        end
      end
      default: n.state = S_IDLE;
    endcase

    if (!q.en) begin // RL2
      n.state  = S_IDLE;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
      n.rep    = 1'b0;
    end
    n.irq = |(n.ists & n.imask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q         <= '0;
      q.state   <= S_IDLE;
      q.code    <= ST_NONE;
      q.data    <= DATA_RST;
      q.ists    <= IRQ_RST;
      q.imask   <= IRQ_RST;
      q.scl_m   <= 1'b1;
      q.scl_s   <= 1'b1;
      q.sda_m   <= 1'b1;
      q.sda_s   <= 1'b1;
      q.sda_p   <= 1'b1;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rvalid  = q.rvalid;
  // outputs only ever pull low; scl_o and sda_o are q.rep anded with zero, so constant zero
  assign scl_o         = q.rep & 1'b0;
  assign sda_o         = q.rep & 1'b0;
  assign scl_oe        = q.scl_oe;
  assign sda_oe        = q.sda_oe;
  assign irq           = q.irq;

endmodule

// *** core/tmr_pkg.sv ***
// constants, register map and state type of the two-wire master receiver
package tmr_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_ISTS = 8'h0C;
  localparam logic [7:0] OFS_IMSK = 8'h10;
  // control register bit positions
  localparam int B_FLAG = 7;
  localparam int B_ACK  = 6;
  localparam int B_STA  = 5;
  localparam int B_STO  = 4;
  localparam int B_WCOL = 3;
  localparam int B_EN   = 2;
  localparam int B_IE   = 0;
  // interrupt status bit positions
  localparam int I_DONE = 0;
  localparam int I_ARB  = 1;
  localparam int I_WCOL = 2;
  // reset values
  localparam logic [7:0] DATA_RST = 8'hFF;
  localparam logic [2:0] IRQ_RST  = 3'h0;
  // status codes, prescaler bits zero
  localparam logic [7:0] ST_START   = 8'h08;
  localparam logic [7:0] ST_RSTART  = 8'h10;
  localparam logic [7:0] ST_AW_ACK  = 8'h18;
  localparam logic [7:0] ST_AW_NACK = 8'h20;
  localparam logic [7:0] ST_DT_ACK  = 8'h28;
  localparam logic [7:0] ST_DT_NACK = 8'h30;
  localparam logic [7:0] ST_ARB     = 8'h38;
  localparam logic [7:0] ST_AR_ACK  = 8'h40;
  localparam logic [7:0] ST_AR_NACK = 8'h48;
  localparam logic [7:0] ST_RX_ACK  = 8'h50;
  localparam logic [7:0] ST_RX_NACK = 8'h58;
  localparam logic [7:0] ST_NONE    = 8'hF8;
  // axi responses
  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_SLV = 2'b10;
  // timing: half of one bus bit period
  localparam int CLK_MHZ  = 100;
  localparam int HALF_NS  = 5000;
  localparam int HALF_CYC = (HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W    = 10;

  typedef enum logic [2:0] {S_IDLE, S_START, S_HOLD, S_BIT, S_STOP, S_RSTART} tmr_state_e;
endpackage

// *** tb/tmr_chk.sv ***
// port-level assertions for the two-wire master receiver
`timescale 1ns/1ps
module tmr_chk
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // bus pins and interrupt
  input wire logic        scl_oe,
  input wire logic        sda_oe,
  input wire logic        irq
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  w_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  // a short low or high phase would break the slowest slave
  scl_low_a: assert property ($rose(scl_oe) |-> scl_oe [*5])
    else $error("clock low phase short");
  scl_high_a: assert property ($fell(scl_oe) |-> !scl_oe [*5])
    else $error("clock high phase short");
  start_gap_a: assert property ($rose(sda_oe) && !scl_oe |-> !scl_oe [*5])
    else $error("start condition too short");
  cover property ($rose(irq));
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLV);
  cover property ($rose(sda_oe) && !scl_oe);
endmodule

bind tmr_core tmr_chk chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .scl_oe, .sda_oe, .irq);

// *** tb/tmr_slave.sv ***
// slave transmitter model on the two-wire bus
`timescale 1ns/1ps
module tmr_slave #(
  parameter logic [6:0] ADDR = 7'h2A,
  parameter logic [7:0] D0   = 8'hA5
) (
  // bus wires and pacing
  input  wire logic       aclk,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [4:0] stretch,
  // pulls, high = line driven low
  output logic            scl_pull,
  output logic            sda_pull
);
  logic       sp, dp, act, rd;
  logic [3:0] n;
  logic [4:0] st;
  logic [7:0] sh, tx;
  assign scl_pull = st != 5'h0;
  initial begin
    {sp, dp, act, rd, n, st, sh, sda_pull} = '0;
    tx = D0;
  end
  always @(posedge aclk) begin
    sp <= scl;
    dp <= sda;
    if (st != 5'h0) st <= st - 5'h1;
    if (scl && sp && dp && !sda) begin
      {act, rd, n, sda_pull} <= {1'h1, 1'h0, 4'h0, 1'h0};
      tx <= D0;
    end else if (scl && sp && !dp && sda) begin
      act <= 1'h0;
    end else if (act && scl && !sp) begin
      sh <= {sh[6:0], sda};
      n  <= (n == 4'h8) ? 4'h0 : n + 4'h1;
      if (n == 4'h8 && !rd) {rd, act} <= {2{sh[7:1] == ADDR && sh[0]}};
      if (n == 4'h8 && rd) begin
        // master refusal ends the read
        if (sda) act <= 1'h0;
        tx <= tx + 8'h1;
      end
    end else if (act && !scl && sp) begin
      st <= stretch;
      if (n == 4'h8) sda_pull <= !rd && sh[7:1] == ADDR && sh[0];
      else sda_pull <= rd && !tx[7 - n];
    end
  end
endmodule

// *** tb/twi_master_receiver_tb_top.sv ***
// self-checking bench for the two-wire master receiver
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, e); end end
module twi_master_receiver_tb_top;
  import tmr_pkg::*;
  localparam logic [7:0] F = 8'h80, A = 8'h40, SA = 8'h20, SO = 8'h10, E = 8'h04, RA = 8'h55, D0 = 8'hA5;
  logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, jam = 0;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, rdt;
  logic [1:0]  br, rr;
  logic        awr, wrdy, bv, arr, rv, scl_oe, sda_oe, so, dao, irq, sscl, ssda;
  logic [4:0]  str = 0;
  int          error_cnt = 0, n_tests = 0;
  wire         scl = !(scl_oe || sscl);
  // jam stands for a second master that pulls the data line low
  wire         sda = !(sda_oe || ssda || jam);
  tmr_core #(.HALF_CYCLES(6)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .scl_i(scl), .scl_o(so), .scl_oe(scl_oe), .sda_i(sda), .sda_o(dao), .sda_oe(sda_oe), .irq(irq));
  tmr_slave #(.ADDR(7'h2A), .D0(D0)) slv (.aclk(aclk), .scl(scl), .sda(sda), .stretch(str),
    .scl_pull(sscl), .sda_pull(ssda));

  // no local limit: only the watchdog ends a wait for the answer
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awa <= a;
    wd  <= {24'h0, d};
    {awv, wv, bry} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'h0;
      if (wrdy) wv <= 1'h0;
    end while (!bv);
    bry <= 1'h0;
    `CHK(br, er)
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    ara <= a;
    {arv, rry} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'h0;
    end while (!rv);
    rry <= 1'h0;
    d = rdt[7:0];
    `CHK(rr, er)
  endtask

  // poll for the flag, judge the status code; a flag that never rises counts
  task automatic wait_flag(input logic [7:0] code);
    logic [7:0] d;
    int k = 0;
    do rd(OFS_CTRL, d, RESP_OK); while (!d[B_FLAG] && ++k < 400);
    `CHK(d[B_FLAG], 1'h1)
    rd(OFS_STAT, d, RESP_OK);
    `CHK(d & 8'hF8, code)
  endtask

  // write control, wait for the flag, judge the status code
  task automatic step(input logic [7:0] c, input logic [7:0] code);
    wr(OFS_CTRL, c, RESP_OK);
    wait_flag(code);
    `CHK(scl_oe, 1'h1)
  endtask

  task automatic stop();
    logic [7:0] d;
    int k = 0;
    wr(OFS_CTRL, F | SO | E, RESP_OK);
    do rd(OFS_CTRL, d, RESP_OK); while (d[B_STO] && ++k < 100);
    `CHK(d[B_STO], 1'h0)
    rd(OFS_STAT, d, RESP_OK);
    `CHK(d & 8'hF8, ST_NONE)
    `CHK({scl, sda}, 2'h3)
  endtask

  task automatic t_regs();
    logic [7:0] d;
    rd(OFS_CTRL, d, RESP_OK);
    `CHK(d, 8'h00)
    rd(OFS_STAT, d, RESP_OK);
    `CHK(d, ST_NONE)
    rd(OFS_DATA, d, RESP_OK);
    `CHK(d, DATA_RST)
    rd(OFS_ISTS, d, RESP_OK);
    `CHK(d, 8'h00)
    rd(8'h14, d, RESP_SLV);
    wr(8'h14, 8'hFF, RESP_SLV);
    `CHK({so, dao}, 2'h0)
    $display("t_regs done");
  endtask

  task automatic t_dis();
    logic [7:0] d;
    wr(OFS_CTRL, F | SA, RESP_OK);
    repeat (60) @(posedge aclk);
    `CHK(sda_oe, 1'h0)
    rd(OFS_STAT, d, RESP_OK);
    `CHK(d, ST_NONE)
    wr(OFS_CTRL, 8'h00, RESP_OK);
    $display("t_dis done");
  endtask

  task automatic t_rx(input logic [4:0] s);
    logic [7:0] d;
    str <= s;
    step(F | SA | E, ST_START);
    wr(OFS_DATA, RA, RESP_OK);
    step(F | A | E, ST_AR_ACK);
    step(F | A | E, ST_RX_ACK);
    rd(OFS_DATA, d, RESP_OK);
    `CHK(d, D0)
    step(F | E, ST_RX_NACK);
    rd(OFS_DATA, d, RESP_OK);
    `CHK(d, D0 + 8'h01)
    stop();
    $display("t_rx done");
  endtask

  task automatic t_restart();
    logic [7:0] d;
    // prescaler bits set so that status reads must be masked
    wr(OFS_STAT, 8'h03, RESP_OK);
    step(F | SA | E, ST_START);
    wr(OFS_DATA, 8'h57, RESP_OK);
    step(F | E, ST_AR_NACK);
    step(F | SA | E, ST_RSTART);
    // write direction after a repeated start must turn transmitter
    wr(OFS_DATA, 8'h54, RESP_OK);
    step(F | E, ST_AW_NACK);
    step(F | SA | E, ST_RSTART);
    wr(OFS_DATA, 8'h57, RESP_OK);
    step(F | E, ST_AR_NACK);
    step(F | SA | SO | E, ST_START);
    wr(OFS_DATA, RA, RESP_OK);
    step(F | E, ST_AR_ACK);
    step(F | E, ST_RX_NACK);
    rd(OFS_DATA, d, RESP_OK);
    `CHK(d, D0)
    step(F | SA | E, ST_RSTART);
    wr(OFS_DATA, RA, RESP_OK);
    step(F | A | E, ST_AR_ACK);
    stop();
    $display("t_restart done");
  endtask

  task automatic t_wcol();
    logic [7:0] d;
    wr(OFS_ISTS, 8'h07, RESP_OK);
    wr(OFS_IMSK, 8'h00, RESP_OK);
    wr(OFS_DATA, 8'h3C, RESP_OK);
    rd(OFS_CTRL, d, RESP_OK);
    `CHK(d[B_WCOL], 1'h1)
    rd(OFS_DATA, d, RESP_OK);
    `CHK(d, RA)
    `CHK(irq, 1'h0)
    wr(OFS_IMSK, 8'h04, RESP_OK);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'h1)
    wr(OFS_ISTS, 8'h04, RESP_OK);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'h0)
    $display("t_wcol done");
  endtask

  task automatic t_arb();
    logic [7:0] d;
    step(F | SA | E, ST_START);
    wr(OFS_DATA, RA, RESP_OK);
    // the second address bit is released high and gets pulled low
    jam <= 1'h1;
    wr(OFS_CTRL, F | E, RESP_OK);
    wait_flag(ST_ARB);
    `CHK({scl_oe, sda_oe}, 2'h0)
    rd(OFS_ISTS, d, RESP_OK);
    `CHK(d[I_ARB], 1'h1)
    // start request while the bus is still taken must wait
    wr(OFS_CTRL, F | SA | E, RESP_OK);
    repeat (40) @(posedge aclk);
    `CHK(sda_oe, 1'h0)
    jam <= 1'h0;
    wait_flag(ST_START);
    wr(OFS_DATA, 8'h57, RESP_OK);
    step(F | E, ST_AR_NACK);
    stop();
    $display("t_arb done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    forever #5 aclk = ~aclk;
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_dis();
    t_rx(5'h0);
    t_rx(5'hF);
    t_arb();
    t_restart();
    t_wcol();
    print_verdict();
  end
  initial begin
    #500000;
    error_cnt++;
    print_verdict();
  end
endmodule
